/* timer2_defs.vh */
`ifndef TIMER2_DEFS_VH
`define TIMER2_DEFS_VH

// Register offsets on the register port.
`define T2_OFS_CTRL_A     8'hB0
`define T2_OFS_CTRL_B     8'hB1
`define T2_OFS_COUNT      8'hB2
`define T2_OFS_CMP_A      8'hB3
`define T2_OFS_CMP_B      8'hB4

// Reset values.
`define T2_CTRL_A_RST     8'h00
`define T2_CTRL_B_RST     4'h0
`define T2_BYTE_RST       8'h00

// Field positions in the control registers.
`define T2_A_MODE_A_HI    7
`define T2_A_MODE_A_LO    6
`define T2_A_MODE_B_HI    5
`define T2_A_MODE_B_LO    4
`define T2_A_WGM_HI       1
`define T2_A_WGM_LO       0
`define T2_B_FORCE_A      7
`define T2_B_FORCE_B      6
`define T2_B_WGM_TOP      3
`define T2_B_CS_HI        2
`define T2_B_CS_LO        0

// Waveform modes.
`define T2_WGM_NORMAL     3'h0
`define T2_WGM_PC_FF      3'h1
`define T2_WGM_CTC        3'h2
`define T2_WGM_FAST_FF    3'h3
`define T2_WGM_PC_OCR     3'h5
`define T2_WGM_FAST_OCR   3'h7

// Counter limits.
`define T2_MAX            8'hFF
`define T2_BOTTOM         8'h00

// Prescaler width, enough for the largest divisor of 1024.
`define T2_PRESC_W        10
`endif

/* timer2_prescaler.v */
`timescale 1ns/1ps
`include "timer2_defs.vh"

module timer2_prescaler #(
   parameter W = `T2_PRESC_W
) (
   input  wire       mclk_i,
   input  wire       sys_rst_i,
   input  wire       clear_i,
   input  wire [2:0] sel_i,
   output reg        tick_o
);

   reg [W-1:0] div_q;

   // Free-running divider; clearing it gives software a defined phase.
   always @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         div_q <= {W{1'b0}};
      end else if (clear_i) begin
         div_q <= {W{1'b0}};
      end else begin
         div_q <= div_q + {{(W-1){1'b0}}, 1'b1};
      end
   end

   // One tick per divided period; code zero stops the counter.
   always @* begin
      case (sel_i)
         3'h0:    tick_o = 1'b0;
         3'h1:    tick_o = 1'b1;
         3'h2:    tick_o = &div_q[2:0];
         3'h3:    tick_o = &div_q[4:0];
         3'h4:    tick_o = &div_q[5:0];
         3'h5:    tick_o = &div_q[6:0];
         3'h6:    tick_o = &div_q[7:0];
         default: tick_o = &div_q[9:0];
      endcase
   end

endmodule // timer2_prescaler

/* timer2_wave_unit.v */
`timescale 1ns/1ps

module timer2_wave_unit #(
   parameter IS_A = 1
) (
   input  wire       mclk_i,
   input  wire       sys_rst_i,
   input  wire [1:0] mode_i,
   input  wire       wgm_top_i,
   input  wire       fast_i,
   input  wire       phase_i,
   input  wire       match_i,
   input  wire       force_i,
   input  wire       wrap_i,
   input  wire       turn_i,
   input  wire       down_i,
   input  wire       eq_top_i,
   output reg        wave_o,
   output wire       connected_o
);

   wire pwm       = fast_i | phase_i;
   // Code 01 only toggles outside PWM, or on channel A with mode bit 2.
   wire toggle_ok = (mode_i == 2'b01) &
                    (~pwm | ((IS_A != 0) & wgm_top_i));
   // A compare value equal to TOP loses its match in PWM modes for codes 10 and 11; the code 01 toggle keeps it.
   wire hit       = match_i & ~(pwm & eq_top_i);

   assign connected_o = mode_i[1] | toggle_ok;

   // The output flop changes only on events of the selected mode.
   always @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         wave_o <= 1'b0;
      end else if (toggle_ok) begin
         if (match_i | force_i) begin
            wave_o <= ~wave_o;
         end
      end else if (mode_i[1]) begin
         if (~pwm) begin
            if (match_i | force_i) begin
               wave_o <= mode_i[0];
            end
         end else if (fast_i) begin
            if (wrap_i) begin
               wave_o <= ~mode_i[0];
            end else if (hit) begin
               wave_o <= mode_i[0];
            end
         end else begin
            if (turn_i & eq_top_i) begin
               wave_o <= ~mode_i[0];
            end else if (hit) begin
               wave_o <= down_i ? ~mode_i[0] : mode_i[0];
            end
         end
      end
   end

endmodule // timer2_wave_unit

/* timer2_waveform_control.v */
`timescale 1ns/1ps
`include "timer2_defs.vh"

// Operation
// - Nonzero output mode code routes the waveform to the pin, not port data, except code 01 in PWM when it is off.
// - Non-PWM channel A: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Non-PWM channel B: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM A: 10 clears at match, sets at bottom; 11 inverts.
// - PWM A code 01 is off, or toggles on match when mode bit 2 set.
// - Fast PWM A codes 10/11 with compare at TOP ignore match, act at bottom.
// - Fast PWM B: 01 reserved; 10 clear match, set bottom; 11 inverts.
// - Phase PWM A: 10 clears on up match, sets on down match; 11 opposite.
// - Phase PWM A codes 10/11 with compare at TOP ignore match, act at TOP.
// - Phase PWM B: 01 reserved; 10 clear up, set down; 11 opposite.
// - PWM B with compare at TOP ignores match, acts at bottom in fast, at TOP in phase.
// - Mode is control A bits 1:0 with control B bit 3 on top.
// - Modes set sequence and TOP; 4 and 6 reserved.
// - Compare update and overflow points depend on the waveform mode.
// - Force A in non-PWM applies channel A code at once.
// - Force A raises no match pulse, never clears counter, reads zero.
// - Force B behaves likewise for channel B.
// - Clock select zero stops counting; code 001 ticks every clock.
// - Codes 010 to 111 divide by 8, 32, 64, 128, 256, 1024.
// - Both compare values are compared continuously with the counter.
module timer2_waveform_control (
   input  wire       mclk_i,
   input  wire       sys_rst_i,
   input  wire [7:0] addr_i,
   input  wire       wr_en_i,
   input  wire       rd_en_i,
   input  wire [7:0] wdata_i,
   output reg  [7:0] rdata_o,
   input  wire       presc_clear_i,
   input  wire       port_a_i,
   input  wire       port_dir_a_i,
   input  wire       port_b_i,
   input  wire       port_dir_b_i,
   output reg        pin_a_o,
   output wire       pin_a_oe_n_o,
   output reg        pin_b_o,
   output wire       pin_b_oe_n_o,
   output reg        overflow_o,
   output reg        match_a_o,
   output reg        match_b_o
);

   reg  [7:0] ctrl_a_q;
   reg  [3:0] ctrl_b_q;
   reg  [7:0] count_q;
   reg        down_q;
   reg        block_q;
   reg  [7:0] cmp_a_buf_q;
   reg  [7:0] cmp_b_buf_q;
   reg  [7:0] cmp_a_q;
   reg  [7:0] cmp_b_q;
   reg  [7:0] count_d;
   reg        down_d;
   wire       tick;
   wire       wave_a;
   wire       wave_b;
   wire       conn_a;
   wire       conn_b;

   // True when the register port addresses the given byte.
   function addr_is;
      input [7:0] addr;
      input [7:0] ofs;
      begin
         addr_is = (addr == ofs);
      end
   endfunction

   // One counter step; both directions wrap modulo 256 on purpose, so a
   // counter left above a new TOP runs round to zero instead of sticking.
   function [7:0] count_step;
      input [7:0] value;
      input       down;
      begin
         count_step = down ? (value - 8'h01) : (value + 8'h01);
      end
   endfunction

   // Mode decode; reserved modes 4 and 6 count like normal mode.
   wire [2:0] wgm = {ctrl_b_q[`T2_B_WGM_TOP],
                     ctrl_a_q[`T2_A_WGM_HI:`T2_A_WGM_LO]};
   wire fast  = (wgm == `T2_WGM_FAST_FF) | (wgm == `T2_WGM_FAST_OCR);
   wire phase = (wgm == `T2_WGM_PC_FF) | (wgm == `T2_WGM_PC_OCR);
   wire clear_on_compare_mode   = (wgm == `T2_WGM_CTC);
   wire pwm   = fast | phase;

   // TOP comes from compare A in modes 2, 5 and 7, else it is MAX.
   wire       top_ocr = clear_on_compare_mode | (wgm == `T2_WGM_PC_OCR) |
                        (wgm == `T2_WGM_FAST_OCR);
   wire [7:0] top     = top_ocr ? cmp_a_q : `T2_MAX;
   wire       at_top  = (count_q == top);
   wire       at_max  = (count_q == `T2_MAX);
   wire       at_bot  = (count_q == `T2_BOTTOM);

   // Register port strobes.
   wire wr_a   = wr_en_i & addr_is(addr_i, `T2_OFS_CTRL_A);
   wire wr_b   = wr_en_i & addr_is(addr_i, `T2_OFS_CTRL_B);
   wire wr_cnt = wr_en_i & addr_is(addr_i, `T2_OFS_COUNT);
   wire wr_ca  = wr_en_i & addr_is(addr_i, `T2_OFS_CMP_A);
   wire wr_cb  = wr_en_i & addr_is(addr_i, `T2_OFS_CMP_B);

   // Force strobes act only outside PWM and are never stored.
   wire force_a = wr_b & wdata_i[`T2_B_FORCE_A] & ~pwm;
   wire force_b = wr_b & wdata_i[`T2_B_FORCE_B] & ~pwm;

   // Timer events, all qualified by the prescaled tick.
   wire wrap_evt = tick & fast & at_top;
   wire turn_evt = tick & phase & ~down_q & at_top;
   wire bot_evt  = tick & phase & down_q & at_bot;
   wire hit_a    = tick & ~block_q & (count_q == cmp_a_q);
   wire hit_b    = tick & ~block_q & (count_q == cmp_b_q);

   // Overflow point per mode.
   wire ovf_evt = phase ? bot_evt :
                  (wgm == `T2_WGM_FAST_OCR) ? (tick & at_top) :
                  (tick & at_max);

   // Prescaler selects the counting rate.
   timer2_prescaler #(
      .W (`T2_PRESC_W)
   ) u_presc (
      .mclk_i    (mclk_i),
      .sys_rst_i (sys_rst_i),
      .clear_i   (presc_clear_i),
      .sel_i     (ctrl_b_q[`T2_B_CS_HI:`T2_B_CS_LO]),
      .tick_o    (tick)
   );

   // Control registers keep only their implemented bits.
   always @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ctrl_a_q <= `T2_CTRL_A_RST;
         ctrl_b_q <= `T2_CTRL_B_RST;
      end else begin
         if (wr_a) begin
            ctrl_a_q <= {wdata_i[7:4], 2'b00, wdata_i[1:0]};
         end
         if (wr_b) begin
            ctrl_b_q <= wdata_i[3:0];
         end
      end
   end

   // Next counter value and direction for the active sequence.
   always @* begin
      count_d = count_q;
      down_d  = down_q;
      if (tick) begin
         if (phase) begin
            if (~down_q) begin
               if (at_top) begin
                  down_d  = 1'b1;
                  count_d = count_step(count_q, 1'b1);
               end else begin
                  count_d = count_step(count_q, 1'b0);
               end
            end else if (at_bot) begin
               down_d  = 1'b0;
               count_d = count_step(count_q, 1'b0);
            end else begin
               count_d = count_step(count_q, 1'b1);
            end
         end else if ((fast | clear_on_compare_mode) & at_top) begin
            count_d = `T2_BOTTOM;
         end else begin
            count_d = count_step(count_q, 1'b0);
         end
      end
      if (~phase) begin
         down_d = 1'b0;
      end
   end

   // Counter; a software write wins over a tick and blocks the next match.
   always @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         count_q <= `T2_BYTE_RST;
         down_q  <= 1'b0;
         block_q <= 1'b0;
      end else if (wr_cnt) begin
         count_q <= wdata_i;
         down_q  <= down_d;
         block_q <= 1'b1;
      end else begin
         count_q <= count_d;
         down_q  <= down_d;
         if (tick) begin
            block_q <= 1'b0;
         end
      end
   end

   // Compare values are double buffered. The buffer always takes the
   // write; the active copy follows at once outside PWM, at TOP in phase
   // correct and at bottom in fast PWM so a duty change never glitches.
   always @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cmp_a_buf_q <= `T2_BYTE_RST;
         cmp_b_buf_q <= `T2_BYTE_RST;
         cmp_a_q     <= `T2_BYTE_RST;
         cmp_b_q     <= `T2_BYTE_RST;
      end else begin
         if (wr_ca) begin
            cmp_a_buf_q <= wdata_i;
         end
         if (wr_cb) begin
            cmp_b_buf_q <= wdata_i;
         end
         if (~pwm | wrap_evt | turn_evt) begin
            cmp_a_q <= cmp_a_buf_q;
            cmp_b_q <= cmp_b_buf_q;
         end
      end
   end

   // Channel A waveform.
   timer2_wave_unit #(
      .IS_A (1)
   ) u_wave_a (
      .mclk_i      (mclk_i),
      .sys_rst_i   (sys_rst_i),
      .mode_i      (ctrl_a_q[`T2_A_MODE_A_HI:`T2_A_MODE_A_LO]),
      .wgm_top_i   (wgm[2]),
      .fast_i      (fast),
      .phase_i     (phase),
      .match_i     (hit_a),
      .force_i     (force_a),
      .wrap_i      (wrap_evt),
      .turn_i      (turn_evt),
      .down_i      (down_q),
      .eq_top_i    (cmp_a_q == top),
      .wave_o      (wave_a),
      .connected_o (conn_a)
   );

   // Channel B waveform.
   timer2_wave_unit #(
      .IS_A (0)
   ) u_wave_b (
      .mclk_i      (mclk_i),
      .sys_rst_i   (sys_rst_i),
      .mode_i      (ctrl_a_q[`T2_A_MODE_B_HI:`T2_A_MODE_B_LO]),
      .wgm_top_i   (wgm[2]),
      .fast_i      (fast),
      .phase_i     (phase),
      .match_i     (hit_b),
      .force_i     (force_b),
      .wrap_i      (wrap_evt),
      .turn_i      (turn_evt),
      .down_i      (down_q),
      .eq_top_i    (cmp_b_q == top),
      .wave_o      (wave_b),
      .connected_o (conn_b)
   );

   // Pin data: waveform when connected, else the ordinary port value.
   always @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pin_a_o <= 1'b0;
         pin_b_o <= 1'b0;
      end else begin
         pin_a_o <= conn_a ? wave_a : port_a_i;
         pin_b_o <= conn_b ? wave_b : port_b_i;
      end
   end

   // The direction bit alone enables the driver, even when overridden.
   assign pin_a_oe_n_o = ~port_dir_a_i;
   assign pin_b_oe_n_o = ~port_dir_b_i;

   // Event pulses; a forced compare is deliberately absent from these.
   always @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         overflow_o <= 1'b0;
         match_a_o  <= 1'b0;
         match_b_o  <= 1'b0;
      end else begin
         overflow_o <= ovf_evt;
         match_a_o  <= hit_a;
         match_b_o  <= hit_b;
      end
   end

   // Read data is registered; force bits and unused bits read zero.
   always @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rdata_o <= `T2_BYTE_RST;
      end else if (rd_en_i) begin
         case (addr_i)
            `T2_OFS_CTRL_A: rdata_o <= ctrl_a_q;
            `T2_OFS_CTRL_B: rdata_o <= {4'h0, ctrl_b_q};
            `T2_OFS_COUNT:  rdata_o <= count_q;
            `T2_OFS_CMP_A:  rdata_o <= cmp_a_buf_q;
            `T2_OFS_CMP_B:  rdata_o <= cmp_b_buf_q;
            default:        rdata_o <= `T2_BYTE_RST;
         endcase
      end
   end

endmodule // timer2_waveform_control

/* timer2_waveform_control_props.sv */
`timescale 1ns/1ps
module timer2_waveform_control_props (
   input wire       mclk_i,
   input wire       sys_rst_i,
   input wire [7:0] addr_i,
   input wire       wr_en_i,
   input wire       rd_en_i,
   input wire [7:0] wdata_i,
   input wire [7:0] rdata_o,
   input wire       presc_clear_i,
   input wire       port_a_i,
   input wire       port_dir_a_i,
   input wire       port_b_i,
   input wire       port_dir_b_i,
   input wire       pin_a_o,
   input wire       pin_a_oe_n_o,
   input wire       pin_b_o,
   input wire       pin_b_oe_n_o,
   input wire       overflow_o,
   input wire       match_a_o,
   input wire       match_b_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   reg  [7:0] ctl_a_q;
   reg  [3:0] ctl_b_q;
   reg  [8:0] quiet_q;
   wire [7:0] view_a = {ctl_a_q[7:4], 2'h0, ctl_a_q[1:0]};
   wire [2:0] wmode = {ctl_b_q[3], ctl_a_q[1:0]};
   wire       wr_b = wr_en_i && (addr_i == 8'hB1);
   // Shadow of the control fields. quiet_q counts cycles since any write,
   // so a period check can excuse a window broken by reprogramming.
   always @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ctl_a_q <= 8'h00;
         ctl_b_q <= 4'h0;
         quiet_q <= 9'h000;
      end else begin
         if (wr_en_i && (addr_i == 8'hB0)) begin
            ctl_a_q <= wdata_i;
         end
         if (wr_b) begin
            ctl_b_q <= wdata_i[3:0];
         end
         if (wr_en_i) begin
            quiet_q <= 9'h000;
         end else if (quiet_q != 9'h1FF) begin
            quiet_q <= quiet_q + 9'h001;
         end
      end
   end
   oe_dir_a: assert property (pin_a_oe_n_o == !port_dir_a_i)
      else $error("pin A enable does not follow direction");
   reada_mask_a: assert property (
      rd_en_i && addr_i == 8'hB0 |=> rdata_o == $past(view_a))
      else $error("control A readback wrong");
   readb_mask_a: assert property (
      rd_en_i && addr_i == 8'hB1 |=> rdata_o == {4'h0, $past(ctl_b_q)})
      else $error("control B readback wrong");
   porta_pass_a: assert property (
      ctl_a_q[7:6] == 2'h0 |=> pin_a_o == $past(port_a_i))
      else $error("pin A does not carry port data");
   portb_pass_a: assert property (
      ctl_a_q[5:4] == 2'h0 |=> pin_b_o == $past(port_b_i))
      else $error("pin B does not carry port data");
   stop_quiet_a: assert property (
      (ctl_b_q[2:0] == 3'h0) [*4] |=> !(match_a_o || match_b_o || overflow_o))
      else $error("event seen while the clock is stopped");
   toggle_edge_a: assert property (
      match_a_o && !ctl_a_q[0] && !ctl_b_q[3] && ctl_a_q[7:6] == 2'h1
      && quiet_q > 9'd4 |=> pin_a_o != $past(pin_a_o))
      else $error("pin A did not toggle with its match");
   force_set_a: assert property (
      wr_b && wdata_i[7] && !wdata_i[3] && !ctl_a_q[0] && ctl_a_q[7]
      |-> ##[1:4] pin_a_o == ctl_a_q[6])
      else $error("forced compare did not reach pin A");
   ovf_period_a: assert property (
      overflow_o && wmode == 3'h0 && ctl_b_q[2:0] == 3'h1 && quiet_q > 9'd8
      |-> ##256 (overflow_o || quiet_q < 9'd256))
      else $error("normal mode overflow period wrong");
endmodule  // timer2_waveform_control_props

bind timer2_waveform_control timer2_waveform_control_props props_i (
   .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
   .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .wdata_i(wdata_i),
   .rdata_o(rdata_o), .presc_clear_i(presc_clear_i),
   .port_a_i(port_a_i), .port_dir_a_i(port_dir_a_i),
   .port_b_i(port_b_i), .port_dir_b_i(port_dir_b_i),
   .pin_a_o(pin_a_o), .pin_a_oe_n_o(pin_a_oe_n_o), .pin_b_o(pin_b_o),
   .pin_b_oe_n_o(pin_b_oe_n_o), .overflow_o(overflow_o),
   .match_a_o(match_a_o), .match_b_o(match_b_o));

/* timer2_pin_side.sv */
`timescale 1ns/1ps
// Port logic behind the compare pins: software's direction and data bits,
// and the level an outside observer sees on each pad.
module timer2_pin_side (
   input  wire       mclk_i,
   input  wire [3:0] sw_i,
   input  wire       pin_a_i,
   input  wire       oe_a_n_i,
   input  wire       pin_b_i,
   input  wire       oe_b_n_i,
   output wire       port_a_o,
   output wire       dir_a_o,
   output wire       port_b_o,
   output wire       dir_b_o,
   output wire       pad_a_o,
   output wire       pad_b_o
);
   reg last_a_q = 1'b0;
   reg last_b_q = 1'b0;
   // Bits are {dir_b, data_b, dir_a, data_a}, set by software off the edge.
   assign {dir_b_o, port_b_o, dir_a_o, port_a_o} = sw_i;
   // These pads have no pull, so a released one shows the inverse of its
   // last driven level and a stale value can never pass for a live one.
   always @(posedge mclk_i) begin
      if (!oe_a_n_i) last_a_q <= pin_a_i;
      if (!oe_b_n_i) last_b_q <= pin_b_i;
   end
   assign pad_a_o = oe_a_n_i ? !last_a_q : pin_a_i;
   assign pad_b_o = oe_b_n_i ? !last_b_q : pin_b_i;
endmodule  // timer2_pin_side

/* test_timer2_waveform_control.sv */
`timescale 1ns/1ps
module test_timer2_waveform_control;
   logic mclk_i = 1'b0, sys_rst_i = 1'b1, wr_en_i = 1'b0, rd_en_i = 1'b0;
   logic presc_clear_i = 1'b0, rd_d1_q = 1'b0, exp_a;
   logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, v, w;
   logic [3:0] sw_q = 4'hA;
   logic [31:0] seed = 32'h00011C7E;
   logic [7:0] exp_q[$];
   logic [1:0] fc [4] = '{2'h3, 2'h2, 2'h1, 2'h1};
   int divs [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
   int errors = 0, samples_checked = 0, cyc = 0, ha, hb, ho, hm, t0, t1;
   wire [7:0] rdata_o;
   wire pin_a_o, pin_a_oe_n_o, pin_b_o, pin_b_oe_n_o, pad_a, pad_b;
   wire overflow_o, match_a_o, match_b_o;
   wire port_a_i, port_dir_a_i, port_b_i, port_dir_b_i;
   timer2_waveform_control dut (
      .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
      .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .wdata_i(wdata_i),
      .rdata_o(rdata_o), .presc_clear_i(presc_clear_i),
      .port_a_i(port_a_i), .port_dir_a_i(port_dir_a_i),
      .port_b_i(port_b_i), .port_dir_b_i(port_dir_b_i),
      .pin_a_o(pin_a_o), .pin_a_oe_n_o(pin_a_oe_n_o), .pin_b_o(pin_b_o),
      .pin_b_oe_n_o(pin_b_oe_n_o), .overflow_o(overflow_o),
      .match_a_o(match_a_o), .match_b_o(match_b_o));
   timer2_pin_side pins (
      .mclk_i(mclk_i), .sw_i(sw_q), .pin_a_i(pin_a_o),
      .oe_a_n_i(pin_a_oe_n_o), .pin_b_i(pin_b_o), .oe_b_n_i(pin_b_oe_n_o),
      .port_a_o(port_a_i), .dir_a_o(port_dir_a_i), .port_b_o(port_b_i),
      .dir_b_o(port_dir_b_i), .pad_a_o(pad_a), .pad_b_o(pad_b));
   initial begin
      forever #5 mclk_i = ~mclk_i;
   end
   // Read data lands one cycle after the strobe; a stuck run is cut off.
   always @(posedge mclk_i) begin
      cyc++;
      if (rd_d1_q) check({8'h00, rdata_o}, {8'h00, exp_q.pop_front()});
      rd_d1_q <= rd_en_i;
      if (cyc == 40000) begin
         errors++;
         tally_and_finish();
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      samples_checked++;
      if (seen !== want) begin
         errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, want);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk_i);
      addr_i = a;
      wdata_i = d;
      wr_en_i = 1'b1;
      @(negedge mclk_i);
      wr_en_i = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge mclk_i);
      addr_i = a;
      rd_en_i = 1'b1;
      exp_q.push_back(e);
      @(negedge mclk_i);
      rd_en_i = 1'b0;
   endtask
   task automatic next_match(output int t);
      int k = 0;
      do begin
         @(negedge mclk_i);
         k++;
      end while (match_a_o !== 1'b1 && k < 3000);
      t = cyc;
   endtask
   // Pin highs, overflow and B match pulses over whole periods, mid-cycle.
   task automatic duty(input int n);
      ha = 0;
      hb = 0;
      ho = 0;
      hm = 0;
      repeat (n) begin
         @(negedge mclk_i);
         ha += int'(pin_a_o === 1'b1);
         hb += int'(pin_b_o === 1'b1);
         ho += int'(overflow_o === 1'b1);
         hm += int'(match_b_o === 1'b1);
      end
   endtask
   // The 600 cycle settle lets a counter above a new TOP wrap home first.
   task automatic pwm(input logic [7:0] b0, input logic [7:0] b1,
                      input int n, input int ea, input int eb);
      wr(8'hB0, b0);
      wr(8'hB1, b1);
      repeat (600) @(negedge mclk_i);
      duty(n);
      check(16'(ha), 16'(ea));
      check(16'(hb), 16'(eb));
   endtask
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   task automatic tally_and_finish;
      $display("checks=%0d errors=%0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (12) @(negedge mclk_i);
      sys_rst_i = 1'b0;
      rd(8'hB0, 8'h00);
      rd(8'hB1, 8'h00);
      wr(8'hB0, 8'hFF);
      rd(8'hB0, 8'hF3);
      wr(8'hB1, 8'h3F);
      rd(8'hB1, 8'h0F);
      wr(8'hB5, 8'hAA);
      rd(8'hB5, 8'h00);
      wr(8'hB1, 8'h00);
      wr(8'hB0, 8'h00);
      // Random compare values and port bits reach the design in earnest.
      repeat (4) begin
         seed = xs(seed);
         wr(8'hB4, seed[15:8]);
         rd(8'hB4, seed[15:8]);
      end
      repeat (200) begin
         @(negedge mclk_i);
         seed = xs(seed);
         sw_q = seed[3:0];
      end
      sw_q = 4'hA;
      // Compare-clear with TOP 1 gives a match every two timer ticks.
      wr(8'hB3, 8'h01);
      wr(8'hB0, 8'h42);
      for (int cs = 1; cs < 8; cs++) begin
         wr(8'hB1, 8'(cs));
         @(negedge mclk_i) presc_clear_i = 1'b1;
         @(negedge mclk_i) presc_clear_i = 1'b0;
         next_match(t0);
         next_match(t0);
         next_match(t1);
         check(16'(t1 - t0), 16'(2 * divs[cs]));
      end
      wr(8'hB1, 8'h00);
      exp_a = 1'b0;
      for (int i = 0; i < 4; i++) begin
         wr(8'hB0, {fc[i], fc[i], 4'h0});
         wr(8'hB1, 8'hC0);
         exp_a = fc[i] == 2'h3 ? 1'b1 : fc[i] == 2'h2 ? 1'b0 : !exp_a;
         repeat (4) @(negedge mclk_i);
         check({15'h0, pin_a_o}, {15'h0, exp_a});
         check({15'h0, pin_b_o}, {15'h0, exp_a});
         check({15'h0, pad_a}, {15'h0, exp_a});
         check({15'h0, pad_b}, {15'h0, exp_a});
      end
      wr(8'hB0, 8'h00);
      wr(8'hB1, 8'h01);
      repeat (300) @(negedge mclk_i);
      duty(1024);
      check(16'(ho), 16'h0004);
      check(16'(hm), 16'h0004);
      seed = xs(seed);
      v = 8'h01 + (seed[7:0] % 8'hFE);
      w = 8'h01 + (seed[15:8] % 8'hFE);
      wr(8'hB3, v);
      wr(8'hB4, w);
      pwm(8'hA3, 8'h01, 256, v + 1, w + 1);
      pwm(8'hF3, 8'h01, 256, 255 - v, 255 - w);
      pwm(8'hA1, 8'h01, 510, 2 * v, 2 * w);
      pwm(8'hF1, 8'h01, 510, 510 - 2 * v, 510 - 2 * w);
      wr(8'hB3, 8'h08);
      wr(8'hB4, 8'h08);
      pwm(8'hA3, 8'h09, 36, 36, 36);
      pwm(8'hA1, 8'h09, 36, 36, 36);
      pwm(8'h43, 8'h09, 36, 18, 0);
      sw_q = 4'hE;
      pwm(8'h53, 8'h01, 36, 0, 36);
      pwm(8'h51, 8'h01, 36, 0, 36);
      tally_and_finish();
   end
endmodule  // test_timer2_waveform_control
